// *** src/dvt_timing.v ***
// Operation
// - vertical total sampled during vertical back porch, and every cycle while the generator is disabled
// - vertical active field kept when its byte enables are off
// - vertical total change stretches or shrinks blank seamlessly
// - blank low-power window: htotal minus sync width, or htotal in event mode
// - byte clocks = ceil(span * bytes per pixel / lanes)
// - transition latency N*17+12 with clock lane low power, else N*7.5+4
// - N = ceil(link MHz / 160)
// - tx time = window minus latency; rx also minus turnaround timeout
// - turnaround timeout counts escape clocks; byte equivalent times N
// - turnaround and receive ownership timers bound panel lane ownership
// - turnaround is 8 fixed steps plus sure plus get, 14 by default
// - default sure 1, get 5 escape clocks, software override allowed
// - threshold crossing counted as one whole escape clock
// - escape bits take two escape clocks each
// - up to 32 read payload bytes per turnaround
// - worst panel return is 709 escape clocks
// - host sends all sync packets; low power only in gaps
`timescale 1ns/10ps
`default_nettype none
`include "dvt_map.vh"
module dvt_timing #(
  parameter W = 16
) (
  input  wire          core_clk,
  input  wire          rst_n,
  input  wire          tg_enable,
  input  wire          vtotal_wr,
  input  wire [1:0]    vtotal_be,
  input  wire [W-1:0]  vtotal_wdata,
  input  wire [W-1:0]  vactive_wdata,
  input  wire [W-1:0]  hactive,
  input  wire [W-1:0]  htotal,
  input  wire [W-1:0]  hsync_start,
  input  wire [W-1:0]  hsync_end,
  input  wire [W-1:0]  vsync_start,
  input  wire          sync_event_mode,
  input  wire [2:0]    bytes_per_pixel,
  input  wire [2:0]    lanes,
  input  wire [W-1:0]  link_mhz,
  input  wire          clk_lane_lp,
  input  wire          ta_override,
  input  wire [7:0]    ta_sure_cfg,
  input  wire [7:0]    ta_get_cfg,
  input  wire [W-1:0]  turnaround_timeout_cfg,
  input  wire [W-1:0]  lowpower_receive_timeout_cfg,
  input  wire [5:0]    max_return_cfg,
  input  wire          lp_req,
  input  wire          lp_req_rx,
  input  wire          panel_returned,
  input  wire          err_clear,
  output reg  [W-1:0]  h_count_q,
  output reg  [W-1:0]  v_count_q,
  output reg           hsync_q,
  output reg           vsync_q,
  output reg           vblank_q,
  output reg           lp_window_q,
  output reg  [W-1:0]  tx_budget_q,
  output reg  [W-1:0]  rx_budget_q,
  output reg  [W-1:0]  fast_to_fast_transition_latency,
  output reg  [7:0]    byte_per_esc_q,
  output reg  [5:0]    max_return_q,
  output reg           lane_owned_q,
  output reg           ta_timeout_err_q,
  output reg           rx_timeout_err_q,
  output wire          lp_grant
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_TA   = 2'h1;
  localparam [1:0] ST_RX   = 2'h2;

  reg [W-1:0] vtotal_q;
  reg [W-1:0] vactive_q;
  reg [W-1:0] vtotal_act_q;
  reg [1:0]   st_q;
  reg [W-1:0] esc_cnt_q;
  reg [7:0]   div_q;
  reg [W-1:0] own_q;

  // ceiling divide by lanes
  function [W-1:0] ceil_div;
    input [W+2:0] num;
    input [2:0]   den;
    reg   [W+2:0] quo;
    begin
      if (den == 3'h0)
        quo = num;
      else
        quo = (num + {{W{1'b0}}, den} - {{(W+2){1'b0}}, 1'b1}) / {{W{1'b0}}, den};
      ceil_div = quo[W-1:0];
    end
  endfunction

  localparam [W+7:0] LINK_DIV  = `DVT_LINK_DIV_MHZ;
  localparam [W+3:0] LP_MUL    = `DVT_LAT_CLKLP_MUL;
  localparam [W+3:0] LP_ADD    = `DVT_LAT_CLKLP_ADD;
  localparam [W+3:0] HS_MUL2   = `DVT_LAT_CLKHS_MUL2;
  localparam [W+3:0] HS_ADD    = `DVT_LAT_CLKHS_ADD;
  localparam [7:0]   TA_FIXED  = `DVT_TA_FIXED_STEPS;
  localparam [7:0]   TA_SURE   = `DVT_TA_SURE_DEF;
  localparam [7:0]   TA_GET    = `DVT_TA_GET_DEF;
  localparam [5:0]   MAX_RET   = `DVT_MAX_RET_BYTES;
  localparam [W-1:0] BYTE_ESC  = 8 * `DVT_ESC_CLK_PER_BIT;
  localparam [W-1:0] WORST_ESC = `DVT_WORST_RX_ESC;
  localparam [W-1:0] FIXED_ESC = WORST_ESC - {{(W-6){1'b0}}, MAX_RET} * BYTE_ESC;

  wire         last_h     = (h_count_q >= htotal);
  wire         last_v     = (v_count_q >= vtotal_act_q);
  wire         in_vbp     = (v_count_q >= vsync_start) && (v_count_q < vtotal_act_q);

  // low-power window of a blanking line, in byte clocks
  wire [W-1:0] sync_w     = hsync_end - hsync_start;
  wire [W-1:0] bllp_px    = sync_event_mode ? htotal : (htotal - sync_w);
  wire [W+2:0] bllp_bytes = {3'h0, bllp_px} * {{W{1'b0}}, bytes_per_pixel};
  wire [W-1:0] bllp_bc    = ceil_div(bllp_bytes, lanes);
  // byte clocks per escape clock, link rate rounded up
  wire [W+7:0] link_up    = {8'h00, link_mhz} + LINK_DIV - {{(W+7){1'b0}}, 1'b1};
  wire [W+7:0] n_full     = link_up / LINK_DIV;
  wire [W-1:0] n_esc      = n_full[W-1:0];
  wire [W+3:0] n_wide     = {4'h0, n_esc};
  wire [W+3:0] lat_lp     = n_wide * LP_MUL + LP_ADD;
  // 7.5 per escape clock as 15/2, half clock rounded up
  wire [W+3:0] lat_hs_x2  = n_wide * HS_MUL2 + {{(W+3){1'b0}}, 1'b1};
  wire [W+3:0] lat_hs     = (lat_hs_x2 >> 1) + HS_ADD;
  wire [W-1:0] lat        = clk_lane_lp ? lat_lp[W-1:0] : lat_hs[W-1:0];
  wire [2*W-1:0] ta_bc    = turnaround_timeout_cfg * n_esc;
  wire [W-1:0] tx_b       = (bllp_bc > lat) ? bllp_bc - lat : {W{1'b0}};
  wire [W-1:0] rx_b       = (tx_b > ta_bc[W-1:0]) ? tx_b - ta_bc[W-1:0] : {W{1'b0}};

  // receive bound without a programmed timeout: worst return for the allowed read size
  wire [W-1:0] pay_esc    = {{(W-6){1'b0}}, max_return_q} * BYTE_ESC;
  wire [W-1:0] need_esc   = FIXED_ESC + pay_esc;
  wire [2*W-1:0] need_bc  = need_esc * n_esc;
  wire [W-1:0] rx_limit   = (lowpower_receive_timeout_cfg != {W{1'b0}}) ?
                            lowpower_receive_timeout_cfg : need_bc[W-1:0];

  // own sequence length: fixed steps incl. threshold step plus sure and get
  wire [7:0]   ta_len     = ta_override ? (TA_FIXED + ta_sure_cfg + ta_get_cfg)
                                        : (TA_FIXED + TA_SURE + TA_GET);

  // escape clock divider: one tick every n_esc byte clocks
  wire [8:0]   div_nx     = {1'b0, div_q} + 9'h001;
  wire         esc_tick   = (div_nx >= {1'b0, n_esc[7:0]});
  wire [W-1:0] esc_nx     = esc_cnt_q + {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] own_nx     = own_q + {{(W-1){1'b0}}, 1'b1};
  wire         in_ta      = (st_q == ST_TA);
  wire         in_rx      = (st_q == ST_RX);
  wire         ta_expire  = in_ta && !panel_returned && esc_tick
                            && (esc_nx >= turnaround_timeout_cfg);
  wire         ta_done    = in_ta && !panel_returned && esc_tick
                            && (esc_nx >= {{(W-8){1'b0}}, ta_len});
  wire         rx_expire  = in_rx && !panel_returned && (own_nx >= rx_limit);

  assign lp_grant = vblank_q && lp_window_q && (st_q == ST_IDLE) && lp_req;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vtotal_q     <= {W{1'b0}};
      vactive_q    <= {W{1'b0}};
      vtotal_act_q <= {W{1'b0}};
      h_count_q    <= {W{1'b0}};
      v_count_q    <= {W{1'b0}};
      hsync_q      <= 1'b0;
      vsync_q      <= 1'b0;
      vblank_q     <= 1'b0;
      lp_window_q  <= 1'b0;
    end
    else
    begin
      if (vtotal_wr)
      begin
        if (vtotal_be[1])
          vtotal_q <= vtotal_wdata;
        if (vtotal_be[0])
          vactive_q <= vactive_wdata;
      end
      if (tg_enable && in_vbp)
        vtotal_act_q <= vtotal_q;
      if (!tg_enable)
      begin
        h_count_q    <= {W{1'b0}};
        v_count_q    <= {W{1'b0}};
        vtotal_act_q <= vtotal_q;
      end
      else if (last_h)
      begin
        h_count_q <= {W{1'b0}};
        v_count_q <= last_v ? {W{1'b0}} : v_count_q + 1'b1;
      end
      else
        h_count_q <= h_count_q + 1'b1;
      hsync_q     <= tg_enable && (h_count_q >= hsync_start) && (h_count_q < hsync_end);
      vsync_q     <= tg_enable && (v_count_q >= vsync_start) && (v_count_q < vtotal_act_q);
      vblank_q    <= tg_enable && (v_count_q >= vactive_q);
      lp_window_q <= sync_event_mode ? 1'b1
                   : !((h_count_q >= hsync_start) && (h_count_q < hsync_end));
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_budget_q <= {W{1'b0}};
      rx_budget_q <= {W{1'b0}};
      fast_to_fast_transition_latency <= {W{1'b0}};
      byte_per_esc_q <= 8'h00;
      max_return_q <= 6'h00;
    end
    else
    begin
      tx_budget_q <= tx_b;
      rx_budget_q <= rx_b;
      fast_to_fast_transition_latency <= lat;
      byte_per_esc_q <= n_esc[7:0];
      max_return_q <= (max_return_cfg > 6'd`DVT_MAX_RET_BYTES) ?
                      6'd`DVT_MAX_RET_BYTES : max_return_cfg;
    end
  end

  // turnaround timer in escape clocks, receive ownership timer in core clocks
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q         <= ST_IDLE;
      div_q        <= 8'h00;
      esc_cnt_q    <= {W{1'b0}};
      own_q        <= {W{1'b0}};
      lane_owned_q <= 1'b0;
    end
    else
    begin
      div_q <= esc_tick ? 8'h00 : div_nx[7:0];
      case (st_q)
        ST_IDLE:
        begin
          if (lp_grant && lp_req_rx)
          begin
            st_q <= ST_TA;
            lane_owned_q <= 1'b1;
            esc_cnt_q <= {W{1'b0}};
            own_q <= {W{1'b0}};
          end
        end
        ST_TA:
        begin
          if (esc_tick)
            esc_cnt_q <= esc_nx;
          if (panel_returned || ta_expire)
          begin
            st_q         <= ST_IDLE;
            lane_owned_q <= 1'b0;
          end
          else if (ta_done)
            st_q <= ST_RX;
        end
        ST_RX:
        begin
          own_q <= own_nx;
          if (panel_returned || rx_expire)
          begin
            st_q         <= ST_IDLE;
            lane_owned_q <= 1'b0;
          end
        end
        default:
        begin
          st_q         <= ST_IDLE;
          lane_owned_q <= 1'b0;
        end
      endcase
    end
  end

  // sticky timeout flags; an expiry in the clear cycle still sets
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ta_timeout_err_q <= 1'b0;
      rx_timeout_err_q <= 1'b0;
    end
    else
    begin
      if (ta_expire)
        ta_timeout_err_q <= 1'b1;
      else if (err_clear)
        ta_timeout_err_q <= 1'b0;
      if (rx_expire)
        rx_timeout_err_q <= 1'b1;
      else if (err_clear)
        rx_timeout_err_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** src/dvt_map.vh ***
`ifndef DVT_MAP_VH
`define DVT_MAP_VH
`define DVT_LINK_DIV_MHZ      160
`define DVT_LAT_CLKLP_MUL     17
`define DVT_LAT_CLKLP_ADD     12
`define DVT_LAT_CLKHS_MUL2    15
`define DVT_LAT_CLKHS_ADD     4
`define DVT_TA_FIXED_STEPS    8
`define DVT_TA_SURE_DEF       1
`define DVT_TA_GET_DEF        5
`define DVT_ESC_CLK_PER_BIT   2
`define DVT_MAX_RET_BYTES     32
`define DVT_WORST_RX_ESC      709
`define DVT_VTOTAL_LEAD_LINES 10
`endif

// *** test/dvt_timing_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module dvt_chk #(parameter W = 16) (
  input wire logic         core_clk,
  input wire logic         rst_n,
  input wire logic         tg_enable,
  input wire logic         lp_req_rx,
  input wire logic         panel_returned,
  input wire logic         err_clear,
  input wire logic [5:0]   max_return_cfg,
  input wire logic [W-1:0] link_mhz,
  input wire logic [W-1:0] v_count_q,
  input wire logic         vblank_q,
  input wire logic [7:0]   byte_per_esc_q,
  input wire logic [5:0]   max_return_q,
  input wire logic         lane_owned_q,
  input wire logic         ta_timeout_err_q,
  input wire logic         rx_timeout_err_q,
  input wire logic         lp_grant
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_return_clamp: assert property ($past(rst_n) |-> max_return_q ==
    ($past(max_return_cfg) > 6'h20 ? 6'h20 : $past(max_return_cfg))) else $error("clamp");
  a_esc_ratio: assert property ($past(rst_n) && $stable(link_mhz) |->
    byte_per_esc_q == (link_mhz + 16'h9f) / 16'ha0) else $error("ratio");
  a_grant_blank: assert property (lp_grant |-> vblank_q && !lane_owned_q) else $error("grant");
  a_own_take: assert property (lp_grant && lp_req_rx |=> lane_owned_q) else $error("own");
  a_own_release: assert property ($fell(lane_owned_q) |->
    $past(panel_returned) || ta_timeout_err_q || rx_timeout_err_q) else $error("release");
  a_ta_sticky: assert property (ta_timeout_err_q && !err_clear |=> ta_timeout_err_q)
    else $error("ta");
  a_rx_sticky: assert property (rx_timeout_err_q && !err_clear |=> rx_timeout_err_q)
    else $error("rx");
  a_idle_hold: assert property (!tg_enable && !$past(tg_enable) |-> v_count_q == '0)
    else $error("idle");
endmodule
bind dvt_timing dvt_chk #(.W(W)) i_dvt_chk (.*);
`default_nettype wire

// *** test/dvt_panel.sv ***
`timescale 1ns/10ps
`default_nettype none
module dvt_panel (
  input wire logic  core_clk,
  input wire logic  lane_owned_q,
  input wire logic [7:0] ret_dly,
  output logic      panel_returned
);
  logic [7:0] cnt_q;
  always @(posedge core_clk) cnt_q <= lane_owned_q ? cnt_q + 8'h01 : 8'h00;
  // hands the lane back after ret_dly cycles, 0 stays silent
  assign panel_returned = lane_owned_q && ret_dly != 8'h00 && cnt_q >= ret_dly;
endmodule
`default_nettype wire

// *** test/tb_dvt_timing.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_dvt_timing;
  logic        core_clk, rst_n, tg_enable, vtotal_wr, sync_event_mode, clk_lane_lp;
  logic        ta_override, lp_req, lp_req_rx, panel_returned, err_clear, hsync_q, vsync_q;
  logic        vblank_q, lp_window_q, lane_owned_q, ta_timeout_err_q, rx_timeout_err_q, lp_grant;
  logic [1:0]  vtotal_be;
  logic [2:0]  bytes_per_pixel, lanes;
  logic [5:0]  max_return_cfg, max_return_q;
  logic [7:0]  ta_sure_cfg, ta_get_cfg, byte_per_esc_q, ret_dly;
  logic [15:0] vtotal_wdata, vactive_wdata, hactive, htotal, hsync_start, hsync_end;
  logic [15:0] vsync_start, link_mhz, turnaround_timeout_cfg, lowpower_receive_timeout_cfg;
  logic [15:0] h_count_q, v_count_q, tx_budget_q, rx_budget_q, fast_to_fast_transition_latency;
  int          checks = 0;
  int          miscompares = 0;
  dvt_timing #(.W(16)) i_dvt_timing (.*);
  dvt_panel i_dvt_panel (.*);
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic budgets;
    int lk[4] = '{160, 480, 161, 320};
    int ev[4] = '{0, 1, 0, 1};
    int bp[4] = '{3, 2, 2, 3};
    int ln[4] = '{3, 1, 2, 3};
    int mr[4] = '{33, 20, 63, 32};
    int n, lat, tx;
    for (int r = 0; r < 4; r++)
    begin
      link_mhz = 16'(lk[r]);
      sync_event_mode = ev[r][0];
      clk_lane_lp = ev[r][0];
      bytes_per_pixel = 3'(bp[r]);
      lanes = 3'(ln[r]);
      max_return_cfg = 6'(mr[r]);
      repeat (4) tick;
      n = (lk[r] + 159) / 160;
      lat = ev[r] ? n * 17 + 12 : (n * 15 + 1) / 2 + 4;
      tx = ((ev[r] ? 100 : 90) * bp[r]) / ln[r] - lat;
      chk(byte_per_esc_q, n);
      chk(fast_to_fast_transition_latency, lat);
      chk(tx_budget_q, tx);
      chk(rx_budget_q, tx - 8 * n);
      chk(max_return_q, mr[r] > 32 ? 32 : mr[r]);
    end
  endtask
  task automatic ta_run(input int to, dly, ov, lo, hi, input logic [1:0] err);
    int c;
    turnaround_timeout_cfg = 16'(to);
    ta_override = ov[0];
    ret_dly = 8'(dly);
    lp_req = 1'b1;
    lp_req_rx = 1'b1;
    for (c = 0; c < 3000 && lp_grant !== 1'b1; c++) tick;
    tick;
    chk(lane_owned_q, 1);
    lp_req = 1'b0;
    lp_req_rx = 1'b0;
    for (c = 1; c < 3000 && lane_owned_q === 1'b1; c++) tick;
    chk(c >= lo && c <= hi, 1);
    chk({ta_timeout_err_q, rx_timeout_err_q}, err);
    err_clear = 1'b1;
    tick;
    err_clear = 1'b0;
    tick;
    chk({ta_timeout_err_q, rx_timeout_err_q}, 0);
  endtask
  task automatic vtot;
    int c;
    logic [15:0] vb0;
    for (c = 0; c < 5000 && vblank_q !== 1'b0; c++) tick;
    for (c = 0; c < 5000 && vblank_q !== 1'b1; c++) tick;
    vb0 = v_count_q;
    for (c = 0; c < 5000 && v_count_q !== 16'h0002; c++) tick;
    // total only, active field masked off
    {vtotal_be, vtotal_wdata, vactive_wdata} = {2'h2, 16'h001a, 16'h0003};
    vtotal_wr = 1'b1;
    tick;
    vtotal_wr = 1'b0;
    for (c = 0; c < 5000 && vblank_q !== 1'b1; c++) tick;
    chk(v_count_q, vb0);
    for (c = 0; c < 5000 && v_count_q !== 16'h001a; c++) tick;
    chk(v_count_q, 16'h001a);
    for (c = 0; c < 500 && v_count_q === 16'h001a; c++) tick;
    chk(v_count_q, 16'h0000);
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    #400000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    {rst_n, tg_enable, vtotal_wr, sync_event_mode, clk_lane_lp, ta_override} = '0;
    {lp_req, lp_req_rx, err_clear, vtotal_be, ret_dly} = '0;
    {hactive, htotal, hsync_start, hsync_end} = {16'h0050, 16'h0064, 16'h000a, 16'h0014};
    {vsync_start, vtotal_wdata, vactive_wdata} = {16'h000e, 16'h0014, 16'h000c};
    {link_mhz, bytes_per_pixel, lanes, max_return_cfg} = {16'h00a0, 3'h3, 3'h3, 6'h20};
    {ta_sure_cfg, ta_get_cfg} = {8'h02, 8'h06};
    {turnaround_timeout_cfg, lowpower_receive_timeout_cfg} = {16'h0008, 16'h0014};
    repeat (3) tick;
    rst_n = 1'b1;
    {vtotal_wr, vtotal_be} = 3'h7;
    tick;
    vtotal_wr = 1'b0;
    tick;
    tg_enable = 1'b1;
    budgets;
    link_mhz = 16'h00a0;
    ta_run(4, 0, 0, 3, 7, 2'h2);
    ta_run(40, 20, 0, 19, 23, 2'h0);
    ta_run(40, 0, 1, 33, 40, 2'h1);
    vtot;
    end_sim;
  end
endmodule
`default_nettype wire
